// *** pkg/pwr_mode_pkg.sv ***
// Constants, types and state layout of the power-mode controller
package pwr_mode_pkg;

   // ==========================================================
   // Register offsets
   localparam logic [7:0] ADDR_MODE    = 8'h00;
   localparam logic [7:0] ADDR_CTRL    = 8'h01;
   localparam logic [7:0] ADDR_STATUS  = 8'h02;
   localparam logic [7:0] ADDR_WAKE_EN = 8'h03;

   // ==========================================================
   // Field positions
   localparam int unsigned MODE_DIV_LSB  = 5;
   localparam int unsigned MODE_LTO_BIT  = 3;
   localparam int unsigned MODE_HTO_BIT  = 2;
   localparam int unsigned MODE_IDLE_BIT = 1;
   localparam int unsigned MODE_SRC_BIT  = 0;
   localparam int unsigned CTRL_KEEP_BIT = 7;
   localparam int unsigned STAT_MODE_LSB = 3;
   localparam int unsigned STAT_PDF_BIT  = 1;
   localparam int unsigned STAT_TO_BIT   = 0;

   // ==========================================================
   // Reset values and codes
   localparam logic [2:0] RST_DIVIDER  = 3'h0;
   localparam logic       RST_IDLE_EN  = 1'h1;
   localparam logic       RST_SRC      = 1'h1;
   localparam logic       RST_KEEP     = 1'h0;
   localparam logic [7:0] RST_WAKE_EN  = 8'h00;
   localparam logic [2:0] DIV_SLOW_MAX = 3'h1;
   localparam logic [2:0] DIV_FAST_MIN = 3'h2;
   localparam logic [5:0] PRE_MASK_ALL = 6'h3F;

   // ==========================================================
   // Timing
   localparam int unsigned CORE_CLK_HZ      = 25000000;
   localparam int unsigned SLOW_OSC_HZ      = 32000;
   localparam int unsigned SLOW_TICK_CYCLES = CORE_CLK_HZ / SLOW_OSC_HZ;
   localparam int unsigned HTO_DELAY_CYCLES = 16;
   localparam int unsigned LTO_DELAY_TICKS  = 2;
   localparam logic [9:0]  SLOW_TICK_LAST   = 10'(SLOW_TICK_CYCLES - 1);
   localparam logic [4:0]  HTO_LAST         = 5'(HTO_DELAY_CYCLES - 1);
   localparam logic [4:0]  LTO_LAST         = 5'(LTO_DELAY_TICKS - 1);

   // ==========================================================
   // Types
   typedef enum logic [4:0] {
      ST_RUN   = 5'h01,
      ST_SLEEP = 5'h02,
      ST_IDLE_CLOCK_STOPPED_MODE = 5'h04,
      ST_IDLE_CLOCK_RUNNING_MODE = 5'h08,
      ST_WAKE  = 5'h10
   } pwr_state_t;

   typedef struct packed {
      logic halt_instr;
      logic watchdog_clear_instr;
      logic ext_reset_wake;
      logic watchdog_overflow;
      logic stack_full;
   } core_evt_t;

   typedef struct packed {
      logic fast_osc_on;
      logic cpu_clk_en;
      logic sys_clk_en;
      logic timebase_clk_en;
      logic slow_clk_en;
   } clk_ctl_t;

   typedef struct packed {
      logic watchdog_counter_clear;
      logic full_reset_req;
      logic watchdog_reset_req;
      logic pc_sp_reset;
      logic resume_next;
   } wake_act_t;

   typedef struct packed {
      pwr_state_t st;
      logic [2:0] sys_clock_divider_sel;
      logic       idle_on_halt_enable;
      logic       clock_source_select;
      logic       sysclk_in_idle_keep;
      logic       power_down_flag;
      logic       watchdog_timeout_flag;
      logic [7:0] porta_wake_enable;
      logic [7:0] porta_prev;
      logic [7:0] wake_blocked;
      logic [7:0] wake_irq;
      logic [7:0] irq_deferred;
      logic       wake_reset;
      logic [9:0] slow_cnt;
      logic [4:0] osc_startup_timer;
      logic       lowspeed_osc_ready;
      logic       highspeed_osc_ready;
      logic       src_active;
      logic [2:0] div_active;
      logic [5:0] pre_cnt;
      logic [7:0] rdata;
      clk_ctl_t   clk;
      wake_act_t  act;
      logic [7:0] irq_service;
   } ctl_state_t;

   localparam ctl_state_t STATE_RESET = '{
      st:                    ST_WAKE,
      sys_clock_divider_sel: RST_DIVIDER,
      idle_on_halt_enable:   RST_IDLE_EN,
      clock_source_select:   RST_SRC,
      sysclk_in_idle_keep:   RST_KEEP,
      porta_wake_enable:     RST_WAKE_EN,
      src_active:            RST_SRC,
      div_active:            RST_DIVIDER,
      wake_reset:            1'h1,
      default:               '0
   };

endpackage

// *** logic/power_mode_switch_wakeup.sv ***
// Power-mode switching, clock gating and wake-up control
`timescale 1ns/10ps

module power_mode_switch_wakeup
   import pwr_mode_pkg::*;
(
   input  logic       core_clk,
   input  logic       rst_b,
   input  logic [7:0] reg_addr,
   input  logic [7:0] reg_wdata,
   input  logic       reg_wr,
   input  logic       reg_rd,
   output logic [7:0] reg_rdata,
   input  core_evt_t  core_evt,
   input  logic [7:0] porta_in,
   input  logic [7:0] irq_req,
   input  logic [7:0] irq_enable,
   output clk_ctl_t   clk_ctl,
   output wake_act_t  wake_act,
   output logic [7:0] irq_service,
   output pwr_state_t mode_state,
   output logic       highspeed_osc_ready,
   output logic       lowspeed_osc_ready
);

   // ==========================================================
   // Decoders
   function automatic logic is_fast(input logic       src,
                                    input logic [2:0] div);
      is_fast = src | (div > DIV_SLOW_MAX);
   endfunction

   function automatic logic fast_tick_due(input logic       src,
                                          input logic [2:0] div,
                                          input logic [5:0] pre);
      logic [5:0] mask;
      mask = PRE_MASK_ALL >> (div - DIV_FAST_MIN);
      fast_tick_due = src | (&(pre | ~mask));
   endfunction

   // ==========================================================
   // State
   ctl_state_t q;
   ctl_state_t d;
   logic       slow_tick;
   logic       cur_tick;
   logic       req_fast;
   logic       req_ready;
   logic       active_ready;
   logic       clk_running;
   logic [7:0] port_fall;
   logic [7:0] wake_irq_now;
   logic [7:0] svc;

   always_comb begin
      d            = q;
      slow_tick    = 1'h0;
      cur_tick     = 1'h0;
      req_fast     = 1'h0;
      req_ready    = 1'h0;
      active_ready = 1'h0;
      clk_running  = 1'h0;
      port_fall    = 8'h00;
      wake_irq_now = 8'h00;
      svc          = 8'h00;
      d.act        = '0;
      d.irq_service = 8'h00;

      // ==========================================================
      // Slow oscillator tick, always running
      slow_tick = (q.slow_cnt == SLOW_TICK_LAST);
      d.slow_cnt = slow_tick ? 10'h000 : q.slow_cnt + 10'h001;

      // ==========================================================
      // Shared start-up timer and ready flags
      if (!q.lowspeed_osc_ready) begin
         if (slow_tick) begin
            if (q.osc_startup_timer == LTO_LAST) begin
               d.lowspeed_osc_ready = 1'h1;
               d.osc_startup_timer  = 5'h00;
            end else begin
               d.osc_startup_timer = q.osc_startup_timer + 5'h01;
            end
         end
      end else if (q.clk.fast_osc_on && !q.highspeed_osc_ready) begin
         if (q.osc_startup_timer == HTO_LAST) begin
            d.highspeed_osc_ready = 1'h1;
            d.osc_startup_timer   = 5'h00;
         end else begin
            d.osc_startup_timer = q.osc_startup_timer + 5'h01;
         end
      end
      d.pre_cnt = q.clk.fast_osc_on ? q.pre_cnt + 6'h01 : 6'h00;

      // ==========================================================
      // System clock selection
      if (q.src_active || (q.div_active > DIV_SLOW_MAX)) begin
         cur_tick = q.highspeed_osc_ready & q.clk.fast_osc_on &
                    fast_tick_due(q.src_active, q.div_active, q.pre_cnt);
         active_ready = q.highspeed_osc_ready;
      end else begin
         cur_tick     = slow_tick & q.lowspeed_osc_ready;
         active_ready = q.lowspeed_osc_ready;
      end
      req_fast  = is_fast(q.clock_source_select, q.sys_clock_divider_sel);
      req_ready = req_fast ? q.highspeed_osc_ready : q.lowspeed_osc_ready;
      clk_running = (q.st == ST_RUN) || (q.st == ST_IDLE_CLOCK_RUNNING_MODE) ||
                    (q.st == ST_WAKE);
      if (clk_running && req_ready && (cur_tick || !active_ready)) begin
         d.src_active = q.clock_source_select;
         d.div_active = q.sys_clock_divider_sel;
      end

      // Fast oscillator only while a fast source is wanted
      d.clk.fast_osc_on = clk_running &&
                          (req_fast || is_fast(q.src_active, q.div_active));
      if (!d.clk.fast_osc_on) begin
         d.highspeed_osc_ready = 1'h0;
      end

      // ==========================================================
      // Gated clock enables
      d.clk.sys_clk_en      = cur_tick &&
                              ((q.st == ST_RUN) || (q.st == ST_IDLE_CLOCK_RUNNING_MODE));
      d.clk.cpu_clk_en      = cur_tick && (q.st == ST_RUN);
      d.clk.timebase_clk_en = slow_tick && (q.st != ST_SLEEP);
      d.clk.slow_clk_en     = slow_tick;

      // ==========================================================
      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_MODE: begin
               d.sys_clock_divider_sel = reg_wdata[MODE_DIV_LSB +: 3];
               d.idle_on_halt_enable   = reg_wdata[MODE_IDLE_BIT];
               d.clock_source_select   = reg_wdata[MODE_SRC_BIT];
            end
            ADDR_CTRL: begin
               d.sysclk_in_idle_keep = reg_wdata[CTRL_KEEP_BIT];
            end
            ADDR_WAKE_EN: begin
               d.porta_wake_enable = reg_wdata;
            end
            default: begin
            end
         endcase
      end

      // Register reads, data valid in the next cycle only
      d.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_MODE: begin
               d.rdata[MODE_DIV_LSB +: 3] = q.sys_clock_divider_sel;
               d.rdata[MODE_LTO_BIT]      = q.lowspeed_osc_ready;
               d.rdata[MODE_HTO_BIT]      = q.highspeed_osc_ready;
               d.rdata[MODE_IDLE_BIT]     = q.idle_on_halt_enable;
               d.rdata[MODE_SRC_BIT]      = q.clock_source_select;
            end
            ADDR_CTRL: begin
               d.rdata[CTRL_KEEP_BIT] = q.sysclk_in_idle_keep;
            end
            ADDR_STATUS: begin
               d.rdata[STAT_MODE_LSB +: 5] = q.st;
               d.rdata[STAT_PDF_BIT]       = q.power_down_flag;
               d.rdata[STAT_TO_BIT]        = q.watchdog_timeout_flag;
            end
            ADDR_WAKE_EN: begin
               d.rdata = q.porta_wake_enable;
            end
            default: begin
            end
         endcase
      end

      // ==========================================================
      // Wake sources
      d.porta_prev = porta_in;
      port_fall    = q.porta_prev & ~porta_in & q.porta_wake_enable;
      wake_irq_now = irq_req & ~q.wake_blocked;

      // ==========================================================
      // Mode sequencer
      unique case (q.st)
         ST_RUN: begin
            if (core_evt.watchdog_clear_instr) begin
               d.power_down_flag = 1'h0;
            end
            svc = q.irq_deferred & irq_enable;
            if ((svc != 8'h00) && !core_evt.stack_full) begin
               d.irq_service  = svc;
               d.irq_deferred = q.irq_deferred & ~svc;
            end
            if (core_evt.ext_reset_wake) begin
               d.act.full_reset_req = 1'h1;
            end else if (core_evt.halt_instr) begin
               // Core clock stops; watchdog counter cleared, PDF set and TO cleared, other registers and ports are left alone
               d.porta_prev                 = porta_in;
               d.act.watchdog_counter_clear = 1'h1;
               d.power_down_flag            = 1'h1;
               d.watchdog_timeout_flag      = 1'h0;
               d.wake_blocked               = irq_req;
               d.wake_irq                   = 8'h00;
               d.wake_reset                 = 1'h0;
               if (!q.idle_on_halt_enable) begin
                  d.st = ST_SLEEP;
               end else if (q.sysclk_in_idle_keep) begin
                  d.st = ST_IDLE_CLOCK_RUNNING_MODE;
               end else begin
                  d.st = ST_IDLE_CLOCK_STOPPED_MODE;
               end
            end else if (core_evt.watchdog_overflow) begin
               d.watchdog_timeout_flag  = 1'h1;
               d.act.watchdog_reset_req = 1'h1;
            end
         end
         ST_SLEEP, ST_IDLE_CLOCK_STOPPED_MODE, ST_IDLE_CLOCK_RUNNING_MODE: begin
            if (core_evt.ext_reset_wake) begin
               d.act.full_reset_req = 1'h1;
               d.wake_reset         = 1'h1;
               d.st                 = ST_WAKE;
            end else if (core_evt.watchdog_overflow) begin
               d.watchdog_timeout_flag = 1'h1;
               d.act.pc_sp_reset       = 1'h1;
               d.wake_reset            = 1'h1;
               d.st                    = ST_WAKE;
            end else if ((port_fall != 8'h00) ||
                         (wake_irq_now != 8'h00)) begin
               d.wake_irq = wake_irq_now;
               d.st       = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (active_ready) begin
               d.st = ST_RUN;
               if (!q.wake_reset) begin
                  svc = q.wake_irq & irq_enable;
                  if ((svc != 8'h00) && !core_evt.stack_full) begin
                     d.irq_service  = svc;
                     d.irq_deferred = q.irq_deferred | (q.wake_irq & ~svc);
                  end else begin
                     d.act.resume_next = 1'h1;
                     d.irq_deferred    = q.irq_deferred | q.wake_irq;
                  end
               end
            end
         end
         default: begin
            d.st = ST_WAKE;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= STATE_RESET;
      end else begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata           = q.rdata;
   assign clk_ctl             = q.clk;
   assign wake_act            = q.act;
   assign irq_service         = q.irq_service;
   assign mode_state          = q.st;
   assign highspeed_osc_ready = q.highspeed_osc_ready;
   assign lowspeed_osc_ready  = q.lowspeed_osc_ready;

endmodule

// *** testbench/pwr_mode_checker_assertions.sv ***
// Port-level assertions of the power-mode controller
`timescale 1ns/10ps
module pwr_mode_checker
   import pwr_mode_pkg::*;
(
   input logic       core_clk,
   input logic       rst_b,
   input core_evt_t  core_evt,
   input clk_ctl_t   clk_ctl,
   input wake_act_t  wake_act,
   input pwr_state_t mode_state,
   input logic       highspeed_osc_ready,
   input logic       lowspeed_osc_ready
);
   logic low_pwr;
   assign low_pwr = mode_state inside {ST_SLEEP, ST_IDLE_CLOCK_STOPPED_MODE, ST_IDLE_CLOCK_RUNNING_MODE};
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ==========================================================
   // Sequences
   sequence s_halt_taken;
      mode_state == ST_RUN && core_evt.halt_instr
         && !core_evt.ext_reset_wake && !core_evt.watchdog_overflow;
   endsequence
   sequence s_hto_wait;
      (!highspeed_osc_ready) [*8] ##[8:9] highspeed_osc_ready;
   endsequence
   // ==========================================================
   // Properties
   property p_halt_entry;
      s_halt_taken |=> low_pwr && wake_act.watchdog_counter_clear;
   endproperty
   property p_entry_cause;
      low_pwr && !$past(low_pwr)
         |-> $past(core_evt.halt_instr) && $past(mode_state) == ST_RUN;
   endproperty
   property p_sleep_clk;
      mode_state == ST_SLEEP && $past(mode_state) == ST_SLEEP
         |-> !clk_ctl.cpu_clk_en && !clk_ctl.sys_clk_en
            && !clk_ctl.timebase_clk_en && !clk_ctl.fast_osc_on;
   endproperty
   property p_idle_clock_stopped_mode_clk;
      mode_state == ST_IDLE_CLOCK_STOPPED_MODE && $past(mode_state) == ST_IDLE_CLOCK_STOPPED_MODE
         |-> !clk_ctl.cpu_clk_en && !clk_ctl.sys_clk_en
            && !clk_ctl.fast_osc_on;
   endproperty
   property p_idle_clock_running_mode_clk;
      mode_state == ST_IDLE_CLOCK_RUNNING_MODE && $past(mode_state) == ST_IDLE_CLOCK_RUNNING_MODE
         |-> !clk_ctl.cpu_clk_en
            && clk_ctl.fast_osc_on == $past(clk_ctl.fast_osc_on);
   endproperty
   property p_hto_low;
      mode_state == ST_SLEEP || mode_state == ST_IDLE_CLOCK_STOPPED_MODE
         |=> !highspeed_osc_ready;
   endproperty
   property p_hto_delay;
      $rose(clk_ctl.fast_osc_on) && lowspeed_osc_ready |-> s_hto_wait;
   endproperty
   property p_fast_wait;
      mode_state == ST_WAKE && clk_ctl.fast_osc_on && !highspeed_osc_ready
         |=> mode_state != ST_RUN;
   endproperty
   property p_ext_wake;
      low_pwr && core_evt.ext_reset_wake
         |=> mode_state == ST_WAKE && wake_act.full_reset_req;
   endproperty
   property p_wdt_wake;
      low_pwr && core_evt.watchdog_overflow && !core_evt.ext_reset_wake
         |=> mode_state == ST_WAKE && wake_act.pc_sp_reset
            && !wake_act.full_reset_req;
   endproperty
   // ==========================================================
   // Assertions
   a_halt_entry: assert property (p_halt_entry)
      else $error("halt did not enter low power");
   a_entry_cause: assert property (p_entry_cause)
      else $error("low power entered without halt");
   a_sleep_clk: assert property (p_sleep_clk)
      else $error("clock running in sleep");
   a_idle_clock_stopped_mode_clk: assert property (p_idle_clock_stopped_mode_clk)
      else $error("clock running in idle_clock_stopped_mode");
   a_idle_clock_running_mode_clk: assert property (p_idle_clock_running_mode_clk)
      else $error("clock changed in idle_clock_running_mode");
   a_hto_low: assert property (p_hto_low)
      else $error("fast ready high while stopped");
   a_hto_delay: assert property (p_hto_delay)
      else $error("fast ready delay wrong");
   a_fast_wait: assert property (p_fast_wait)
      else $error("run before fast ready");
   a_ext_wake: assert property (p_ext_wake)
      else $error("external reset wake missing");
   a_wdt_wake: assert property (p_wdt_wake)
      else $error("watchdog wake missing");
endmodule

bind power_mode_switch_wakeup pwr_mode_checker u_chk (
   .core_clk, .rst_b, .core_evt, .clk_ctl, .wake_act, .mode_state,
   .highspeed_osc_ready, .lowspeed_osc_ready
);

// *** testbench/core_model.sv ***
// Processor core model issuing halt and instruction events
`timescale 1ns/10ps
module core_model
   import pwr_mode_pkg::*;
(
   input  logic       core_clk,
   input  logic       rst_b,
   input  core_evt_t  req,
   input  pwr_state_t mode_state,
   output core_evt_t  core_evt
);
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         core_evt <= '0;
      end else begin
         core_evt <= req;
         // Halt executes only while the core runs
         core_evt.halt_instr <= req.halt_instr && mode_state == ST_RUN;
      end
   end
endmodule

// *** testbench/power_mode_switch_wakeup_tb.sv ***
// Self-checking bench of the power-mode controller
`timescale 1ns/10ps
module power_mode_switch_wakeup_tb;
   import pwr_mode_pkg::*;
   typedef struct packed {
      logic [7:0] m;
      logic [7:0] c;
      pwr_state_t s;
   } row_t;
   logic       core_clk, rst_b, reg_wr, reg_rd;
   logic       highspeed_osc_ready, lowspeed_osc_ready;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, porta_in;
   logic [7:0] irq_req, irq_enable, irq_service;
   core_evt_t  req, core_evt;
   clk_ctl_t   clk_ctl;
   wake_act_t  wake_act;
   pwr_state_t mode_state;
   int         num_errors, comparisons, cycles, i;
   row_t       rows [3] = '{'{8'h01, 8'h00, ST_SLEEP},
      '{8'h03, 8'h00, ST_IDLE_CLOCK_STOPPED_MODE}, '{8'h03, 8'h80, ST_IDLE_CLOCK_RUNNING_MODE}};

   power_mode_switch_wakeup uut (.core_clk, .rst_b, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .core_evt, .porta_in, .irq_req,
      .irq_enable, .clk_ctl, .wake_act, .irq_service, .mode_state,
      .highspeed_osc_ready, .lowspeed_osc_ready);
   core_model u_core (.core_clk, .rst_b, .req, .mode_state, .core_evt);

   // ==========================================================
   // Tasks
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      check(reg_rdata, exp);
   endtask
   task automatic evt(input core_evt_t e);
      @(posedge core_clk);
      req <= e;
      @(posedge core_clk);
      req <= '0;
      @(posedge core_clk);
      #1;
   endtask
   task automatic pin_fall(input logic [7:0] v);
      @(posedge core_clk);
      porta_in <= v;
      @(posedge core_clk);
      porta_in <= 8'hFF;
      #1;
   endtask
   task automatic wait_for(input pwr_state_t s);
      for (int n = 0; n < 3000 && mode_state !== s; n++) begin
         @(posedge core_clk);
         #1;
      end
      check({3'h0, mode_state}, {3'h0, s});
   endtask

   // ==========================================================
   // Clock and timeout
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      rst_b = 1'b0;
      {reg_addr, reg_wdata, reg_wr, reg_rd, irq_req, irq_enable} = '0;
      req = '0;
      porta_in = 8'hFF;
      repeat (3) @(posedge core_clk);
      #1;
      check({3'h0, mode_state}, {3'h0, ST_WAKE});
      check({3'h0, clk_ctl}, 8'h00);
      rst_b <= 1'b1;
      rd(ADDR_MODE, 8'h03);
      rd(ADDR_CTRL, 8'h00);
      rd(ADDR_STATUS, 8'h80);
      rd(ADDR_WAKE_EN, 8'h00);
      rd(8'h04, 8'h00);
      wait_for(ST_RUN);
      check({7'h0, wake_act.resume_next}, 8'h00);
      rd(ADDR_MODE, 8'h0F);
      wr(ADDR_STATUS, 8'hFF);
      rd(ADDR_STATUS, 8'h08);
      for (i = 0; i < 3; i++) begin
         wr(ADDR_MODE, rows[i].m);
         wr(ADDR_CTRL, rows[i].c);
         wr(ADDR_WAKE_EN, 8'h01);
         evt(5'h10);
         check({3'h0, mode_state}, {3'h0, rows[i].s});
         check({7'h0, wake_act.watchdog_counter_clear}, 8'h01);
         rd(ADDR_STATUS, {rows[i].s, 3'h2});
         pin_fall(8'hFD);
         check({3'h0, mode_state}, {3'h0, rows[i].s});
         pin_fall(8'hFE);
         check({3'h0, mode_state}, {3'h0, ST_WAKE});
         wait_for(ST_RUN);
         check({7'h0, wake_act.resume_next}, 8'h01);
      end
      evt(5'h08);
      rd(ADDR_STATUS, 8'h08);
      wr(ADDR_MODE, 8'h01);
      evt(5'h10);
      evt(5'h02);
      check({7'h0, wake_act.pc_sp_reset}, 8'h01);
      wait_for(ST_RUN);
      rd(ADDR_STATUS, 8'h0B);
      evt(5'h10);
      rd(ADDR_STATUS, 8'h12);
      evt(5'h04);
      check({7'h0, wake_act.full_reset_req}, 8'h01);
      wait_for(ST_RUN);
      evt(5'h02);
      check({7'h0, wake_act.watchdog_reset_req}, 8'h01);
      check({3'h0, mode_state}, {3'h0, ST_RUN});
      irq_enable <= 8'h04;
      irq_req <= 8'h02;
      wr(ADDR_MODE, 8'h03);
      wr(ADDR_CTRL, 8'h80);
      evt(5'h10);
      repeat (5) @(posedge core_clk);
      #1;
      check({3'h0, mode_state}, {3'h0, ST_IDLE_CLOCK_RUNNING_MODE});
      irq_req <= 8'h06;
      wait_for(ST_RUN);
      check(irq_service, 8'h04);
      check({7'h0, wake_act.resume_next}, 8'h00);
      irq_req <= 8'h00;
      irq_enable <= 8'h00;
      evt(5'h10);
      irq_req <= 8'h08;
      wait_for(ST_RUN);
      check({7'h0, wake_act.resume_next}, 8'h01);
      check(irq_service, 8'h00);
      irq_req <= 8'h00;
      irq_enable <= 8'h08;
      for (i = 0; i < 10 && irq_service !== 8'h08; i++) begin
         @(posedge core_clk);
         #1;
      end
      check(irq_service, 8'h08);
      wr(ADDR_MODE, 8'h02);
      for (i = 0; i < 2000 && clk_ctl.fast_osc_on !== 1'b0; i++) begin
         @(posedge core_clk);
         #1;
      end
      check({7'h0, clk_ctl.fast_osc_on}, 8'h00);
      rd(ADDR_MODE, 8'h0A);
      wr(ADDR_MODE, 8'h42);
      for (i = 0; i < 2000 && highspeed_osc_ready !== 1'b1; i++) begin
         @(posedge core_clk);
         #1;
      end
      rd(ADDR_MODE, 8'h4E);
      finish_test();
   end
endmodule
